// ==== hw/sevrep_pkg.sv ====
// Package for the status event reporting block: bit map, commands, presets
package sevrep_pkg;

    localparam int unsigned REG_W = 16;

    // ------------------------------------------------------------------
    // Operation group bit positions
    // ------------------------------------------------------------------
    localparam int unsigned OP_AWAITING_TRIGGER      = 5;
    localparam int unsigned OP_TRANSIENT_ARMED       = 6;
    localparam int unsigned OP_CONSTANT_VOLTAGE      = 8;
    localparam int unsigned OP_TRANSIENT_DONE        = 9;
    localparam int unsigned OP_CONSTANT_CURRENT      = 10;
    localparam int unsigned OP_SAMPLE_DONE           = 11;
    localparam int unsigned OP_LIST_DONE             = 12;
    localparam int unsigned OP_LIST_RUNNING          = 14;
    localparam logic [15:0] OP_USED_MASK             = 16'h5f60;

    // ------------------------------------------------------------------
    // Questionable group bit positions
    // ------------------------------------------------------------------
    localparam int unsigned QS_VOLTAGE_REG_FAULT     = 0;
    localparam int unsigned QS_CURRENT_REG_FAULT     = 1;
    localparam int unsigned QS_THERMAL_FAULT         = 3;
    localparam int unsigned QS_FOLLOWER_UNIT_FAULT   = 6;
    localparam int unsigned QS_VOLTAGE_FAULT         = 12;
    localparam int unsigned QS_CURRENT_FAULT         = 13;
    localparam int unsigned QS_ENERGY_ABSORBING      = 14;
    localparam logic [15:0] QS_USED_MASK             = 16'h704b;
    localparam logic [15:0] QS_LATCH_MASK            = 16'h3000;

    // ------------------------------------------------------------------
    // Status byte summary positions, presets and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SB_QUES_SUMMARY          = 3;
    localparam int unsigned SB_OPER_SUMMARY          = 7;
    localparam logic [15:0] OP_ENABLE_PRESET         = 16'h2001;
    localparam logic [15:0] QS_ENABLE_PRESET         = 16'h00ff;
    localparam logic [15:0] ENABLE_RESET             = 16'h0000;

    // Command codes carried on the command port
    typedef enum logic [3:0] {
        SEV_CMD_NONE,
        SEV_CMD_OPER_COND_Q,
        SEV_CMD_OPER_EVENT_Q,
        SEV_CMD_OPER_ENAB,
        SEV_CMD_OPER_ENAB_Q,
        SEV_CMD_QUES_COND_Q,
        SEV_CMD_QUES_EVENT_Q,
        SEV_CMD_QUES_ENAB,
        SEV_CMD_QUES_ENAB_Q,
        SEV_CMD_PRESET
    } sevrep_cmd_t;

    // Command request as it travels on the port
    typedef struct packed {
        logic        valid;
        sevrep_cmd_t cmd;
        logic [15:0] data;
    } sevrep_req_t;

    // Query answer
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sevrep_rsp_t;

endpackage

// ==== hw/sevrep_group.sv ====
// One status group: event latch with clear on read, enable mask, summary
`timescale 1ns/1ps
`default_nettype none
module sevrep_group #(
    parameter int unsigned   WIDTH      = 16,
    parameter logic [15:0]   LATCH_MASK = 16'hffff,
    parameter logic [15:0]   USED_MASK  = 16'hffff,
    parameter logic [15:0]   PRESET_VAL = 16'h0000
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] cond_i,
    input  wire logic             event_read_i,
    input  wire logic             enable_write_i,
    input  wire logic [WIDTH-1:0] enable_data_i,
    input  wire logic             preset_i,
    output logic      [WIDTH-1:0] cond_o,
    output logic      [WIDTH-1:0] event_o,
    output logic      [WIDTH-1:0] enable_o,
    output logic                  summary_o
);
    import sevrep_pkg::*;

    logic [WIDTH-1:0] cond_q;
    logic [WIDTH-1:0] event_q;
    logic [WIDTH-1:0] enable_q;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] next_event;
    logic [WIDTH-1:0] next_enable;

    // ------------------------------------------------------------------
    // Edge capture and event latch
    // ------------------------------------------------------------------
    // Only rising edges of latchable, used bits become events
    assign rise       = cond_i & ~cond_q & LATCH_MASK[WIDTH-1:0] & USED_MASK[WIDTH-1:0];
    // New edge in a read cycle survives: set wins over the clear
    assign next_event = (event_read_i ? '0 : event_q) | rise;
    assign next_enable = preset_i ? PRESET_VAL[WIDTH-1:0]
                       : (enable_write_i ? enable_data_i : enable_q);

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_q   <= '0;
            event_q  <= '0;
            enable_q <= ENABLE_RESET[WIDTH-1:0];
        end else if (ce_i) begin
            cond_q   <= cond_i;
            event_q  <= next_event;
            enable_q <= next_enable;
        end
    end

    // Condition is a live view, never latched
    assign cond_o    = cond_i & USED_MASK[WIDTH-1:0];
    assign event_o   = event_q;
    assign enable_o  = enable_q;
    assign summary_o = |(event_q & enable_q);
endmodule
`default_nettype wire

// ==== hw/sevrep_top.sv ====
// Status event reporting: operation and questionable groups with command port
`timescale 1ns/1ps
`default_nettype none
module sevrep_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire logic                 list_running_i,
    input  wire logic                 list_done_i,
    input  wire logic                 sample_done_i,
    input  wire logic                 constant_current_state_i,
    input  wire logic                 transient_done_i,
    input  wire logic                 constant_voltage_state_i,
    input  wire logic                 transient_armed_i,
    input  wire logic                 awaiting_trigger_i,
    input  wire logic                 energy_absorbing_i,
    input  wire logic                 current_fault_i,
    input  wire logic                 voltage_fault_i,
    input  wire logic                 follower_unit_fault_i,
    input  wire logic                 thermal_fault_i,
    input  wire logic                 current_regulation_fault_i,
    input  wire logic                 voltage_regulation_fault_i,
    input  wire sevrep_pkg::sevrep_req_t req_i,
    output sevrep_pkg::sevrep_rsp_t   rsp_o,
    output logic                      oper_summary_o,
    output logic                      ques_summary_o,
    output logic [7:0]                status_byte_o
);
    import sevrep_pkg::*;

    logic [REG_W-1:0] op_cond;
    logic [REG_W-1:0] qs_cond;
    logic [REG_W-1:0] op_cond_v;
    logic [REG_W-1:0] op_event_v;
    logic [REG_W-1:0] op_enable_v;
    logic [REG_W-1:0] qs_cond_v;
    logic [REG_W-1:0] qs_event_v;
    logic [REG_W-1:0] qs_enable_v;
    logic             op_sum;
    logic             qs_sum;
    logic             take;
    logic             is_query;
    logic             answer_take;
    logic             op_event_rd;
    logic             op_enab_wr;
    logic             qs_event_rd;
    logic             qs_enab_wr;
    logic             preset_hit;
    logic             sel_op_cond;
    logic             sel_op_event;
    logic             sel_op_enable;
    logic             sel_qs_cond;
    logic             sel_qs_event;
    logic             sel_qs_enable;
    logic [REG_W-1:0] next_rsp_data;
    sevrep_rsp_t      rsp_q;

    // Query decode, used for answer validity only; selection uses cmd_match
    function automatic logic cmd_is_query(input sevrep_cmd_t c);
        return (c == SEV_CMD_OPER_COND_Q) || (c == SEV_CMD_OPER_EVENT_Q)
            || (c == SEV_CMD_OPER_ENAB_Q) || (c == SEV_CMD_QUES_COND_Q)
            || (c == SEV_CMD_QUES_EVENT_Q) || (c == SEV_CMD_QUES_ENAB_Q);
    endfunction

    // Single command match, shared by every strobe and answer select
    function automatic logic cmd_match(input sevrep_cmd_t c, input sevrep_cmd_t want);
        return c == want;
    endfunction

    // ------------------------------------------------------------------
    // Condition assembly from the supply's state pins
    // ------------------------------------------------------------------
    always_comb begin
        op_cond = '0;
        op_cond[OP_LIST_RUNNING]     = list_running_i;
        op_cond[OP_LIST_DONE]        = list_done_i;
        op_cond[OP_SAMPLE_DONE]      = sample_done_i;
        op_cond[OP_CONSTANT_CURRENT] = constant_current_state_i;
        op_cond[OP_TRANSIENT_DONE]   = transient_done_i;
        op_cond[OP_CONSTANT_VOLTAGE] = constant_voltage_state_i;
        op_cond[OP_TRANSIENT_ARMED]  = transient_armed_i;
        op_cond[OP_AWAITING_TRIGGER] = awaiting_trigger_i;
    end

    always_comb begin
        qs_cond = '0;
        qs_cond[QS_ENERGY_ABSORBING]    = energy_absorbing_i;
        qs_cond[QS_CURRENT_FAULT]       = current_fault_i;
        qs_cond[QS_VOLTAGE_FAULT]       = voltage_fault_i;
        qs_cond[QS_FOLLOWER_UNIT_FAULT] = follower_unit_fault_i;
        qs_cond[QS_THERMAL_FAULT]       = thermal_fault_i;
        qs_cond[QS_CURRENT_REG_FAULT]   = current_regulation_fault_i;
        qs_cond[QS_VOLTAGE_REG_FAULT]   = voltage_regulation_fault_i;
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // A command counts only on an edge with valid and the clock enable high.
    // A query answers one edge later with a single-cycle valid pulse; a write
    // or the preset answers nothing and shows on readback from the next cycle.
    // Unknown codes are dropped silently, so a stray code never touches state.
    // Nothing holds the port off: commands may follow each other every cycle.
    assign take        = req_i.valid & ce_i;
    assign is_query    = cmd_is_query(req_i.cmd);
    assign answer_take = take & is_query;

    // One strobe per register action; a command held valid keeps its strobe high every cycle
    assign op_event_rd = take & cmd_match(req_i.cmd, SEV_CMD_OPER_EVENT_Q);
    assign op_enab_wr  = take & cmd_match(req_i.cmd, SEV_CMD_OPER_ENAB);
    assign qs_event_rd = take & cmd_match(req_i.cmd, SEV_CMD_QUES_EVENT_Q);
    assign qs_enab_wr  = take & cmd_match(req_i.cmd, SEV_CMD_QUES_ENAB);
    assign preset_hit  = take & cmd_match(req_i.cmd, SEV_CMD_PRESET);

    // Answer source select, one-hot by construction of the command code
    assign sel_op_cond   = cmd_match(req_i.cmd, SEV_CMD_OPER_COND_Q);
    assign sel_op_event  = cmd_match(req_i.cmd, SEV_CMD_OPER_EVENT_Q);
    assign sel_op_enable = cmd_match(req_i.cmd, SEV_CMD_OPER_ENAB_Q);
    assign sel_qs_cond   = cmd_match(req_i.cmd, SEV_CMD_QUES_COND_Q);
    assign sel_qs_event  = cmd_match(req_i.cmd, SEV_CMD_QUES_EVENT_Q);
    assign sel_qs_enable = cmd_match(req_i.cmd, SEV_CMD_QUES_ENAB_Q);

    // ------------------------------------------------------------------
    // Operation group: every used bit latches on its rising edge
    // ------------------------------------------------------------------
    // Masks keep all sixteen written bits, so readback always matches the write
    sevrep_group #(
        .WIDTH      (REG_W),
        .LATCH_MASK (OP_USED_MASK),
        .USED_MASK  (OP_USED_MASK),
        .PRESET_VAL (OP_ENABLE_PRESET)
    ) u_oper (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .cond_i         (op_cond),
        .event_read_i   (op_event_rd),
        .enable_write_i (op_enab_wr),
        .enable_data_i  (req_i.data),
        .preset_i       (preset_hit),
        .cond_o         (op_cond_v),
        .event_o        (op_event_v),
        .enable_o       (op_enable_v),
        .summary_o      (op_sum)
    );

    // Questionable group: only current and voltage fault bits latch
    // Bits 14, 6, 3, 1 and 0 stay live only, so an event read never shows them
    sevrep_group #(
        .WIDTH      (REG_W),
        .LATCH_MASK (QS_LATCH_MASK),
        .USED_MASK  (QS_USED_MASK),
        .PRESET_VAL (QS_ENABLE_PRESET)
    ) u_ques (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ce_i           (ce_i),
        .cond_i         (qs_cond),
        .event_read_i   (qs_event_rd),
        .enable_write_i (qs_enab_wr),
        .enable_data_i  (req_i.data),
        .preset_i       (preset_hit),
        .cond_o         (qs_cond_v),
        .event_o        (qs_event_v),
        .enable_o       (qs_enable_v),
        .summary_o      (qs_sum)
    );

    // ------------------------------------------------------------------
    // Answer selection; event reads return the value before the clear
    // ------------------------------------------------------------------
    // Unknown codes select nothing, so their answer data would read zero
    assign next_rsp_data = ({REG_W{sel_op_cond}}   & op_cond_v)
                         | ({REG_W{sel_op_event}}  & op_event_v)
                         | ({REG_W{sel_op_enable}} & op_enable_v)
                         | ({REG_W{sel_qs_cond}}   & qs_cond_v)
                         | ({REG_W{sel_qs_event}}  & qs_event_v)
                         | ({REG_W{sel_qs_enable}} & qs_enable_v);

    // ------------------------------------------------------------------
    // Answer register
    // ------------------------------------------------------------------
    // Valid one cycle, data held until the next answer; holding the data
    // lets a slow reader pick it up late without a second query
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_q <= '0;
        end else if (ce_i) begin
            rsp_q.valid <= answer_take;
            if (answer_take) begin
                rsp_q.data <= next_rsp_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    // Summary bits are combinational from latched events and masks
    assign rsp_o          = rsp_q;
    assign oper_summary_o = op_sum;
    assign ques_summary_o = qs_sum;
    always_comb begin
        status_byte_o = 8'h00;
        status_byte_o[SB_OPER_SUMMARY] = op_sum;
        status_byte_o[SB_QUES_SUMMARY] = qs_sum;
    end
endmodule
`default_nettype wire

// ==== verification/sevrep_sva.sv ====
// Assertion checker for the status event reporting top, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module sevrep_sva (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    ce_i,
    input wire sevrep_pkg::sevrep_req_t req_i,
    input wire sevrep_pkg::sevrep_rsp_t rsp_o,
    input wire logic                    oper_summary_o,
    input wire logic                    ques_summary_o,
    input wire logic [7:0]              status_byte_o
);
    import sevrep_pkg::*;
    // ------------------------------------------------------------------
    // Command decode helpers
    // ------------------------------------------------------------------
    // Queries are the only commands that earn an answer
    wire logic take_w  = ce_i && req_i.valid;
    wire logic query_w = take_w && (req_i.cmd inside {SEV_CMD_OPER_COND_Q, SEV_CMD_OPER_EVENT_Q,
        SEV_CMD_OPER_ENAB_Q, SEV_CMD_QUES_COND_Q, SEV_CMD_QUES_EVENT_Q, SEV_CMD_QUES_ENAB_Q});
    // Summaries may only drop after a read, a mask write or a preset
    wire logic op_clr_w = take_w && (req_i.cmd inside {SEV_CMD_OPER_EVENT_Q, SEV_CMD_OPER_ENAB, SEV_CMD_PRESET});
    wire logic qs_clr_w = take_w && (req_i.cmd inside {SEV_CMD_QUES_EVENT_Q, SEV_CMD_QUES_ENAB, SEV_CMD_PRESET});

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    chk_oper_sb_bit: assert property (status_byte_o[7] == oper_summary_o)
        else $error("status bit 7 differs from operation summary");
    chk_ques_sb_bit: assert property (status_byte_o[3] == ques_summary_o)
        else $error("status bit 3 differs from questionable summary");
    chk_sb_spare_zero: assert property (status_byte_o[6:4] == 3'h0 && status_byte_o[2:0] == 3'h0)
        else $error("unused status byte bit set");
    chk_query_answer: assert property (query_w |=> rsp_o.valid)
        else $error("query without answer");
    chk_no_stray_answer: assert property ((ce_i && !query_w) |=> !rsp_o.valid)
        else $error("answer without query");
    chk_enab_readback: assert property ((take_w && req_i.cmd == SEV_CMD_OPER_ENAB) ##1
        (take_w && req_i.cmd == SEV_CMD_OPER_ENAB_Q) |=> rsp_o.data == $past(req_i.data, 2))
        else $error("enable readback differs from written value");
    chk_preset_value: assert property ((take_w && req_i.cmd == SEV_CMD_PRESET) ##1
        (take_w && req_i.cmd == SEV_CMD_OPER_ENAB_Q) |=> rsp_o.data == 16'h2001)
        else $error("preset operation enable value wrong");
    chk_oper_hold_latch: assert property (($fell(oper_summary_o) && !$past(rst_i)) |-> $past(op_clr_w))
        else $error("operation summary dropped without read");
    chk_ques_hold_latch: assert property (($fell(ques_summary_o) && !$past(rst_i)) |-> $past(qs_clr_w))
        else $error("questionable summary dropped without read");
endmodule

bind sevrep_top sevrep_sva sevrep_sva_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
    .rsp_o(rsp_o), .oper_summary_o(oper_summary_o), .ques_summary_o(ques_summary_o),
    .status_byte_o(status_byte_o));
`default_nettype wire

// ==== verification/sevrep_top_tb.sv ====
// Self-checking bench for the status event reporting top
`timescale 1ns/1ps
`default_nettype none
module sevrep_top_tb;
    import sevrep_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        oper_sum;
    logic        ques_sum;
    logic [15:0] op_c;
    logic [15:0] qs_c;
    sevrep_req_t req_i;
    sevrep_rsp_t rsp_o;
    logic [7:0]  status_byte_o;
    int          mismatches = 0;
    int          tests_run  = 0;
    int          cycles     = 0;
    int unsigned op_pos [8] = '{14, 12, 11, 10, 9, 8, 6, 5};
    int unsigned qs_pos [7] = '{14, 13, 12, 6, 3, 1, 0};

    // Clock enable is driven so a frozen cycle can be checked
    sevrep_top sevrep_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .list_running_i(op_c[14]), .list_done_i(op_c[12]), .sample_done_i(op_c[11]),
        .constant_current_state_i(op_c[10]), .transient_done_i(op_c[9]),
        .constant_voltage_state_i(op_c[8]), .transient_armed_i(op_c[6]), .awaiting_trigger_i(op_c[5]),
        .energy_absorbing_i(qs_c[14]), .current_fault_i(qs_c[13]), .voltage_fault_i(qs_c[12]),
        .follower_unit_fault_i(qs_c[6]), .thermal_fault_i(qs_c[3]),
        .current_regulation_fault_i(qs_c[1]), .voltage_regulation_fault_i(qs_c[0]),
        .req_i(req_i), .rsp_o(rsp_o), .oper_summary_o(oper_sum), .ques_summary_o(ques_sum),
        .status_byte_o(status_byte_o));

    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Ceiling far above the 66 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask

    // Status byte and both summary pins against one expected byte
    task automatic chk_status(input logic [7:0] exp);
        chk({8'h00, status_byte_o}, {8'h00, exp});
        chk({14'h0000, oper_sum, ques_sum}, {14'h0000, exp[SB_OPER_SUMMARY], exp[SB_QUES_SUMMARY]});
    endtask

    // Request held through one rising edge; valid stays up for a follow-on
    task automatic send(input sevrep_cmd_t c, input logic [15:0] d);
        req_i = '{1'b1, c, d};
        @(negedge clk_i);
    endtask

    // One edge with no request, so a held command is not repeated
    task automatic idle();
        req_i.valid = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic query(input sevrep_cmd_t c, input logic [15:0] exp);
        send(c, 16'h0000);
        chk({15'h0000, rsp_o.valid}, 16'h0001);
        chk(rsp_o.data, exp);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        ce_i  = 1'b1;
        op_c  = 16'h0000;
        qs_c  = 16'h0000;
        req_i = '0;
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        query(SEV_CMD_OPER_ENAB_Q, 16'h0000);
        send(SEV_CMD_PRESET, 16'h0000);
        query(SEV_CMD_OPER_ENAB_Q, 16'h2001);
        query(SEV_CMD_QUES_ENAB_Q, 16'h00ff);
        send(SEV_CMD_OPER_ENAB, 16'ha5c3);
        query(SEV_CMD_OPER_ENAB_Q, 16'ha5c3);
        send(SEV_CMD_QUES_ENAB, 16'hffff);
        query(SEV_CMD_QUES_ENAB_Q, 16'hffff);
        // Unknown code must stay silent
        send(sevrep_cmd_t'(4'hf), 16'h0000);
        chk({15'h0000, rsp_o.valid}, 16'h0000);
        // Each operation bit: live view, single latch, clear on read
        send(SEV_CMD_OPER_ENAB, 16'hffff);
        for (int k = 0; k < 8; k++) begin
            op_c = 16'h0001 << op_pos[k];
            query(SEV_CMD_OPER_COND_Q, op_c);
            chk_status(8'h80);
            query(SEV_CMD_OPER_EVENT_Q, op_c);
            query(SEV_CMD_OPER_EVENT_Q, 16'h0000);
            chk_status(8'h00);
        end
        // Each questionable bit: only the two error bits latch
        for (int k = 0; k < 7; k++) begin
            qs_c = 16'h0001 << qs_pos[k];
            query(SEV_CMD_QUES_COND_Q, qs_c);
            chk_status(((qs_c & QS_LATCH_MASK) != 16'h0000) ? 8'h08 : 8'h00);
            query(SEV_CMD_QUES_EVENT_Q, qs_c & QS_LATCH_MASK);
            query(SEV_CMD_QUES_EVENT_Q, 16'h0000);
        end
        // Masked event stays out of the summary until a second, enabled one latches
        op_c = 16'h0400;
        send(SEV_CMD_OPER_ENAB, 16'h0100);
        query(SEV_CMD_OPER_COND_Q, 16'h0400);
        chk_status(8'h00);
        op_c = 16'h0500;
        idle();
        chk_status(8'h80);
        query(SEV_CMD_OPER_EVENT_Q, 16'h0500);
        // Frozen block takes no command: the write below must not land
        ce_i = 1'b0;
        send(SEV_CMD_OPER_ENAB, 16'h0000);
        ce_i = 1'b1;
        query(SEV_CMD_OPER_ENAB_Q, 16'h0100);
        finish_test();
    end
endmodule
`default_nettype wire
